// >>> core/rtc_pkg.sv
/*
 Constants shared by the real-time clock core: register addresses, control bit
 positions, reset values, BCD limits and crystal prescaler figures.
 Assumes a single core clock domain; the crystal input is sampled, not used as a clock.
*/
package rtc_pkg;
	localparam int          NIB_W       = 4;
	localparam int          N_COUNT     = 13;
	// register addresses
	localparam logic [3:0]  A_SEC1      = 4'h0;
	localparam logic [3:0]  A_SEC10     = 4'h1;
	localparam logic [3:0]  A_MIN1      = 4'h2;
	localparam logic [3:0]  A_MIN10     = 4'h3;
	localparam logic [3:0]  A_HR1       = 4'h4;
	localparam logic [3:0]  A_HR10      = 4'h5;
	localparam logic [3:0]  A_DAY1      = 4'h6;
	localparam logic [3:0]  A_DAY10     = 4'h7;
	localparam logic [3:0]  A_MON1      = 4'h8;
	localparam logic [3:0]  A_MON10     = 4'h9;
	localparam logic [3:0]  A_YR1       = 4'hA;
	localparam logic [3:0]  A_YR10      = 4'hB;
	localparam logic [3:0]  A_WEEK      = 4'hC;
	localparam logic [3:0]  A_CTRL_D    = 4'hD;
	localparam logic [3:0]  A_CTRL_E    = 4'hE;
	localparam logic [3:0]  A_CTRL_F    = 4'hF;
	// control bit positions
	localparam int          D_ADJ       = 3;
	localparam int          D_IRQ       = 2;
	localparam int          D_BUSY      = 1;
	localparam int          D_HOLD      = 0;
	localparam int          E_ITRPT     = 1;
	localparam int          E_MASK      = 0;
	localparam int          F_24H       = 2;
	localparam int          F_STOP      = 1;
	localparam int          F_RESET     = 0;
	localparam int          HR10_PM     = 2;
	// reset values
	localparam logic [3:0]  RST_ZERO    = 4'h0;
	localparam logic [3:0]  RST_ONE     = 4'h1;
	localparam logic [3:0]  RST_CTRL_E  = 4'h0;
	localparam logic [3:0]  RST_CTRL_F  = 4'h0;
	// BCD limits
	localparam logic [3:0]  TOP_9       = 4'h9;
	localparam logic [3:0]  TOP_5       = 4'h5;
	localparam logic [3:0]  TOP_WEEK    = 4'h6;
	localparam logic [3:0]  SEC10_HALF  = 4'h3;
	localparam logic [7:0]  HR24_LAST   = 8'h23;
	localparam logic [7:0]  HR12_NOON   = 8'h12;
	localparam logic [7:0]  HR12_ELEVEN = 8'h11;
	localparam logic [7:0]  HR12_ONE    = 8'h01;
	localparam logic [7:0]  MON_FEB     = 8'h02;
	localparam logic [7:0]  MON_APR     = 8'h04;
	localparam logic [7:0]  MON_JUN     = 8'h06;
	localparam logic [7:0]  MON_SEP     = 8'h09;
	localparam logic [7:0]  MON_NOV     = 8'h11;
	localparam logic [7:0]  MON_DEC     = 8'h12;
	localparam logic [7:0]  DIM_FEB     = 8'h28;
	localparam logic [7:0]  DIM_LEAP    = 8'h29;
	localparam logic [7:0]  DIM_SHORT   = 8'h30;
	localparam logic [7:0]  DIM_LONG    = 8'h31;
	// crystal prescaler: 32768 edges per second, 64 Hz sub tick every 512 edges
	localparam int          PRE_W       = 15;
	localparam logic [14:0] PRE_LAST    = 15'h7FFF;
	localparam logic [8:0]  PRE_64_LAST = 9'h1FF;
	localparam logic [7:0]  PULSE_LEN   = 8'h80;
	typedef enum logic [1:0] {PER_64HZ, PER_SEC, PER_MIN, PER_HOUR} period_t;
endpackage

// >>> core/rtc_bus_front.sv
/*
 Host bus front end: address latch with pass-through, strobe synchronisers
 and write capture. Assumes bus inputs are synchronous to the core clock.
*/
`timescale 1ns/100ps
module rtc_bus_front
	import rtc_pkg::*;
(
	// clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_resetn,
	// host pins
	input  wire logic             i_ale,
	input  wire logic [3:0]       i_addr,
	input  wire logic             i_select_active_low,
	input  wire logic             i_standby_select,
	input  wire logic             i_rd_n,
	input  wire logic             i_wr_n,
	input  wire logic [NIB_W-1:0] i_data,
	// internal side
	output logic      [3:0]       o_acc_addr,
	output logic                  o_acc_sel,
	output logic                  o_rd_active,
	output logic                  o_wr_idle,
	output logic                  o_wr_commit,
	output logic      [3:0]       o_wr_addr,
	output logic      [NIB_W-1:0] o_wr_data
);
	import rtc_pkg::*;

	logic [3:0]       lat_addr_reg, lat_addr_next;
	logic             lat_sel_n_reg, lat_sel_n_next;
	logic [2:0]       rd_sync_reg, wr_sync_reg;
	logic [3:0]       cap_addr_reg, cap_addr_next;
	logic [NIB_W-1:0] cap_data_reg, cap_data_next;
	logic             cap_sel_reg, cap_sel_next;

	// transparent while ALE is high, frozen after its fall; tied high it passes through
	always_comb
	begin
		lat_addr_next  = i_ale ? i_addr : lat_addr_reg;
		lat_sel_n_next = i_ale ? i_select_active_low : lat_sel_n_reg;
		o_acc_addr     = i_ale ? i_addr : lat_addr_reg;
		o_acc_sel      = !(i_ale ? i_select_active_low : lat_sel_n_reg)
			&& i_standby_select;
		// data and address sampled while the strobe is low, committed at its end
		cap_addr_next  = !i_wr_n ? o_acc_addr : cap_addr_reg;
		cap_data_next  = !i_wr_n ? i_data : cap_data_reg;
		cap_sel_next   = !i_wr_n ? o_acc_sel : cap_sel_reg;
		o_rd_active    = !rd_sync_reg[1];
		o_wr_idle      = wr_sync_reg[1];
		// commit only after the strobe is through the synchroniser; a counter update may fall in the same cycle
		o_wr_commit    = wr_sync_reg[1] && !wr_sync_reg[2] && cap_sel_reg;
		o_wr_addr      = cap_addr_reg;
		o_wr_data      = cap_data_reg;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			lat_addr_reg  <= RST_ZERO;
			lat_sel_n_reg <= 1'b1;
			rd_sync_reg   <= 3'h7;
			wr_sync_reg   <= 3'h7;
			cap_addr_reg  <= RST_ZERO;
			cap_data_reg  <= RST_ZERO;
			cap_sel_reg   <= 1'b0;
		end
		else
		begin
			lat_addr_reg  <= lat_addr_next;
			lat_sel_n_reg <= lat_sel_n_next;
			rd_sync_reg   <= {rd_sync_reg[1:0], i_rd_n};
			wr_sync_reg   <= {wr_sync_reg[1:0], i_wr_n};
			cap_addr_reg  <= cap_addr_next;
			cap_data_reg  <= cap_data_next;
			cap_sel_reg   <= cap_sel_next;
		end
	end
endmodule

// >>> core/rtc_prescaler.sv
/*
 Crystal prescaler: samples the crystal input, counts its rising edges and
 gives one-second and 64 Hz ticks. Assumes crystal is far slower than the core clock.
*/
`timescale 1ns/100ps
module rtc_prescaler
	import rtc_pkg::*;
(
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_resetn,
	// crystal and control
	input  wire logic i_crystal_in,
	input  wire logic i_run,
	input  wire logic i_clear,
	// ticks
	output logic      o_xtal_edge,
	output logic      o_tick_sec,
	output logic      o_tick_64,
	output logic      o_crystal_out
);
	import rtc_pkg::*;

	logic [2:0]       xs_reg;
	logic [PRE_W-1:0] pre_reg, pre_next;
	logic             inv_reg;

	always_comb
	begin
		o_xtal_edge = xs_reg[1] && !xs_reg[2];
		pre_next    = pre_reg;
		if (i_clear)
			pre_next = '0;
		else if (i_run && o_xtal_edge)
			pre_next = PRE_W'(pre_reg + 1'b1);
		o_tick_sec  = i_run && !i_clear && o_xtal_edge && (pre_reg == PRE_LAST);
		o_tick_64   = i_run && !i_clear && o_xtal_edge && (pre_reg[8:0] == PRE_64_LAST);
		o_crystal_out = inv_reg;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			xs_reg  <= 3'h0;
			pre_reg <= '0;
			inv_reg <= 1'b1;
		end
		else
		begin
			xs_reg  <= {xs_reg[1:0], i_crystal_in};
			pre_reg <= pre_next;
			inv_reg <= !xs_reg[1];
		end
	end
endmodule

// >>> core/rtc_core.sv
/*
 Real-time clock and calendar with a 4-bit RAM-like host bus and a periodic
 open-drain output. Assumes synchronous bus inputs and a sampled 32.768 kHz crystal.
*/
// How it works
// - nibble data, 4-bit address per access
// - respond only while active-low select low
// - standby input low ignores bus, keeps time
// - ALE high passes address, falling edge latches
// - write strobe stores nibble at address
// - drive data only on selected read
// - open-drain periodic interrupt or pulse output
// - periodic output ignores both selects
// - all time counters are BCD digits
// - software bit selects 12 or 24 hours
// - adjust rounds seconds to nearest minute
// - leap years extend February automatically
// - seconds divided from 32.768 kHz crystal
// - counters at 0 to C, control above
// - 24h runs 0-23, 12h runs 12-11
`timescale 1ns/100ps
module rtc_core
	import rtc_pkg::*;
(
	// clock and reset
	input  wire logic                      i_core_clk,
	input  wire logic                      i_resetn,
	// host bus
	input  wire logic                      i_ale,
	input  wire logic [3:0]                i_addr,
	input  wire logic                      i_select_active_low,
	input  wire logic                      i_standby_select,
	input  wire logic                      i_rd_n,
	input  wire logic                      i_wr_n,
	input  wire logic [rtc_pkg::NIB_W-1:0] i_data,
	output logic      [rtc_pkg::NIB_W-1:0] o_data,
	output logic                           o_data_oe,
	// crystal
	input  wire logic                      i_crystal_in,
	output logic                           o_crystal_out,
	// periodic open-drain output
	output logic                           o_periodic_pulse_out,
	output logic                           o_periodic_pulse_out_oe
);
	import rtc_pkg::*;

	logic [3:0] cnt_reg [0:N_COUNT-1];
	logic [3:0] cnt_next [0:N_COUNT-1];
	logic [3:0] ctrl_e_reg, ctrl_e_next, ctrl_f_reg, ctrl_f_next;
	logic       hold_reg, hold_next, pend_reg, pend_next, irq_reg, irq_next;
	logic [7:0] pulse_reg, pulse_next;
	logic [3:0] rd_data_reg, rd_data_next;
	logic       oe_reg, oe_next, od_oe_reg, od_oe_next, od_val_reg;
	logic       xtal_out_reg;

	logic [3:0]       acc_addr, wr_addr;
	logic [NIB_W-1:0] wr_data;
	logic             acc_sel, rd_active, wr_idle, wr_commit;
	logic             xtal_edge, tick_sec, tick_64, crystal_out;
	logic             adv, adj, sec_c, min_c, hr_c, day_c, mon_c, c, leap, ev;
	logic [7:0]       hv, dim;
	period_t          per;

	rtc_bus_front u_front (
		.i_core_clk          (i_core_clk),
		.i_resetn            (i_resetn),
		.i_ale               (i_ale),
		.i_addr              (i_addr),
		.i_select_active_low (i_select_active_low),
		.i_standby_select    (i_standby_select),
		.i_rd_n              (i_rd_n),
		.i_wr_n              (i_wr_n),
		.i_data              (i_data),
		.o_acc_addr          (acc_addr),
		.o_acc_sel           (acc_sel),
		.o_rd_active         (rd_active),
		.o_wr_idle           (wr_idle),
		.o_wr_commit         (wr_commit),
		.o_wr_addr           (wr_addr),
		.o_wr_data           (wr_data)
	);

	rtc_prescaler u_pre (
		.i_core_clk    (i_core_clk),
		.i_resetn      (i_resetn),
		.i_crystal_in  (i_crystal_in),
		.i_run         (!ctrl_f_reg[F_STOP]),
		.i_clear       (ctrl_f_reg[F_RESET]),
		.o_xtal_edge   (xtal_edge),
		.o_tick_sec    (tick_sec),
		.o_tick_64     (tick_64),
		.o_crystal_out (crystal_out)
	);

	// returns {carry, next digit}
	function automatic logic [4:0] bump(input logic [3:0] d, input logic [3:0] top);
		bump = (d >= top) ? {1'b1, RST_ZERO} : {1'b0, 4'(d + 4'h1)};
	endfunction

	// bits marked unused read as zero
	function automatic logic [3:0] read_mask(input logic [3:0] a);
		unique case (a)
			A_SEC10, A_MIN10, A_WEEK: read_mask = 4'h7;
			A_HR10:                   read_mask = 4'h7;
			A_DAY10:                  read_mask = 4'h3;
			A_MON10:                  read_mask = 4'h1;
			default:                  read_mask = 4'hF;
		endcase
	endfunction

	// timekeeping chain
	always_comb
	begin
		for (int i = 0; i < N_COUNT; i++)
			cnt_next[i] = cnt_reg[i];
		// hold defers one pending second so a host read sees a steady snapshot
		adv       = !hold_reg && (tick_sec || pend_reg);
		pend_next = hold_reg && (pend_reg || tick_sec);
		adj       = wr_commit && (wr_addr == A_CTRL_D) && wr_data[D_ADJ];
		sec_c     = 1'b0;
		min_c     = 1'b0;
		hr_c      = 1'b0;
		day_c     = 1'b0;
		mon_c     = 1'b0;
		c         = 1'b0;
		hv        = {2'b00, cnt_reg[A_HR10][1:0], cnt_reg[A_HR1]};
		leap      = cnt_reg[A_YR10][0]
			? (cnt_reg[A_YR1] == 4'h2 || cnt_reg[A_YR1] == 4'h6)
			: (cnt_reg[A_YR1] == 4'h0 || cnt_reg[A_YR1] == 4'h4 || cnt_reg[A_YR1] == 4'h8);
		unique case ({3'b000, cnt_reg[A_MON10][0], cnt_reg[A_MON1]})
			MON_FEB:                            dim = leap ? DIM_LEAP : DIM_FEB;
			MON_APR, MON_JUN, MON_SEP, MON_NOV: dim = DIM_SHORT;
			default:                            dim = DIM_LONG;
		endcase
		if (adj)
		begin
			// round to the nearest minute, at most thirty seconds either way
			sec_c               = cnt_reg[A_SEC10] >= SEC10_HALF;
			cnt_next[A_SEC1]    = RST_ZERO;
			cnt_next[A_SEC10]   = RST_ZERO;
		end
		else if (adv)
		begin
			{c, cnt_next[A_SEC1]} = bump(cnt_reg[A_SEC1], TOP_9);
			if (c)
				{sec_c, cnt_next[A_SEC10]} = bump(cnt_reg[A_SEC10], TOP_5);
		end
		if (sec_c)
		begin
			{c, cnt_next[A_MIN1]} = bump(cnt_reg[A_MIN1], TOP_9);
			if (c)
				{min_c, cnt_next[A_MIN10]} = bump(cnt_reg[A_MIN10], TOP_5);
		end
		if (min_c)
		begin
			hr_c = 1'b1;
			if (ctrl_f_reg[F_24H])
			begin
				if (hv == HR24_LAST)
				begin
					cnt_next[A_HR1]  = RST_ZERO;
					cnt_next[A_HR10] = RST_ZERO;
					day_c            = 1'b1;
				end
				else
				begin
					{c, cnt_next[A_HR1]} = bump(cnt_reg[A_HR1], TOP_9);
					if (c)
						cnt_next[A_HR10] = 4'(cnt_reg[A_HR10] + 4'h1);
				end
			end
			else if (hv == HR12_NOON)
			begin
				cnt_next[A_HR1]        = HR12_ONE[3:0];
				cnt_next[A_HR10][1:0]  = HR12_ONE[5:4];
			end
			else if (hv == HR12_ELEVEN)
			begin
				cnt_next[A_HR1]          = HR12_NOON[3:0];
				cnt_next[A_HR10][1:0]    = HR12_NOON[5:4];
				cnt_next[A_HR10][HR10_PM] = !cnt_reg[A_HR10][HR10_PM];
				day_c                    = cnt_reg[A_HR10][HR10_PM];
			end
			else
			begin
				{c, cnt_next[A_HR1]} = bump(cnt_reg[A_HR1], TOP_9);
				if (c)
					cnt_next[A_HR10][0] = 1'b1;
			end
		end
		if (day_c)
		begin
			{c, cnt_next[A_WEEK]} = bump(cnt_reg[A_WEEK], TOP_WEEK);
			if ({cnt_reg[A_DAY10], cnt_reg[A_DAY1]} == dim)
			begin
				cnt_next[A_DAY1]  = RST_ONE;
				cnt_next[A_DAY10] = RST_ZERO;
				mon_c             = 1'b1;
			end
			else
			begin
				{c, cnt_next[A_DAY1]} = bump(cnt_reg[A_DAY1], TOP_9);
				if (c)
					cnt_next[A_DAY10] = 4'(cnt_reg[A_DAY10] + 4'h1);
			end
		end
		if (mon_c)
		begin
			if ({cnt_reg[A_MON10], cnt_reg[A_MON1]} == MON_DEC)
			begin
				cnt_next[A_MON1]  = RST_ONE;
				cnt_next[A_MON10] = RST_ZERO;
				{c, cnt_next[A_YR1]} = bump(cnt_reg[A_YR1], TOP_9);
				if (c)
					{c, cnt_next[A_YR10]} = bump(cnt_reg[A_YR10], TOP_9);
			end
			else
			begin
				{c, cnt_next[A_MON1]} = bump(cnt_reg[A_MON1], TOP_9);
				if (c)
					cnt_next[A_MON10] = RST_ONE;
			end
		end
		// a host write wins over a same-cycle count
		if (wr_commit && wr_addr <= A_WEEK)
			cnt_next[wr_addr] = wr_data & read_mask(wr_addr);
	end

	// control, periodic output and read path
	always_comb
	begin
		ctrl_e_next = ctrl_e_reg;
		ctrl_f_next = ctrl_f_reg;
		hold_next   = hold_reg;
		if (wr_commit && wr_addr == A_CTRL_D)
			hold_next = wr_data[D_HOLD];
		if (wr_commit && wr_addr == A_CTRL_E)
			ctrl_e_next = wr_data;
		if (wr_commit && wr_addr == A_CTRL_F)
			ctrl_f_next = wr_data;
		per = period_t'(ctrl_e_reg[3:2]);
		unique case (per)
			PER_64HZ: ev = tick_64;
			PER_SEC:  ev = adv;
			PER_MIN:  ev = sec_c;
			PER_HOUR: ev = hr_c;
		endcase
		// writing zero clears the flag; an event in that same cycle still sets it
		irq_next = ev || (irq_reg && !(wr_commit && wr_addr == A_CTRL_D && !wr_data[D_IRQ]));
		if (ev)
			pulse_next = PULSE_LEN;
		else if (xtal_edge && pulse_reg != 8'h00)
			pulse_next = 8'(pulse_reg - 8'h01);
		else
			pulse_next = pulse_reg;
		// selects take no part here
		od_oe_next = !ctrl_e_next[E_MASK] && (ctrl_e_next[E_ITRPT] ? irq_next
			: (pulse_next != 8'h00));
		unique case (acc_addr)
			A_CTRL_D: rd_data_next = {1'b0, irq_reg, pend_reg, hold_reg};
			A_CTRL_E: rd_data_next = ctrl_e_reg;
			A_CTRL_F: rd_data_next = ctrl_f_reg;
			default:  rd_data_next = cnt_reg[acc_addr] & read_mask(acc_addr);
		endcase
		oe_next = rd_active && wr_idle && acc_sel;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			for (int i = 0; i < N_COUNT; i++)
				cnt_reg[i] <= (i == A_DAY1 || i == A_MON1) ? RST_ONE : RST_ZERO;
			ctrl_e_reg   <= RST_CTRL_E;
			ctrl_f_reg   <= RST_CTRL_F;
			hold_reg     <= 1'b0;
			pend_reg     <= 1'b0;
			irq_reg      <= 1'b0;
			pulse_reg    <= 8'h00;
			rd_data_reg  <= RST_ZERO;
			oe_reg       <= 1'b0;
			od_oe_reg    <= 1'b0;
			od_val_reg   <= 1'b0;
			xtal_out_reg <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < N_COUNT; i++)
				cnt_reg[i] <= cnt_next[i];
			ctrl_e_reg   <= ctrl_e_next;
			ctrl_f_reg   <= ctrl_f_next;
			hold_reg     <= hold_next;
			pend_reg     <= pend_next;
			irq_reg      <= irq_next;
			pulse_reg    <= pulse_next;
			rd_data_reg  <= rd_data_next;
			oe_reg       <= oe_next;
			od_oe_reg    <= od_oe_next;
			od_val_reg   <= 1'b0;
			xtal_out_reg <= crystal_out;
		end
	end

	assign o_data                  = rd_data_reg;
	assign o_data_oe               = oe_reg;
	assign o_periodic_pulse_out    = od_val_reg;
	assign o_periodic_pulse_out_oe = od_oe_reg;
	assign o_crystal_out           = xtal_out_reg;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	a_read_drive:   assert property (rd_active && wr_idle && acc_sel |=> o_data_oe)
		else $error("read not driven");
	a_read_float:   assert property (!rd_active |=> !o_data_oe)
		else $error("data driven without read");
	a_select_gate:  assert property (!acc_sel |=> !o_data_oe)
		else $error("data driven while deselected");
	a_standby_idle: assert property (!i_standby_select |=> !o_data_oe)
		else $error("data driven in standby");
	a_write_store:  assert property (wr_commit && wr_addr == A_WEEK
		|=> cnt_reg[A_WEEK] == (($past(wr_data)) & 4'h7))
		else $error("week write lost");
	a_hour_wrap:    assert property (min_c && ctrl_f_reg[F_24H] && hv == HR24_LAST && !wr_commit
		|=> cnt_reg[A_HR1] == 4'h0 && cnt_reg[A_HR10] == 4'h0)
		else $error("24h wrap wrong");
	a_adj_round:    assert property (adj ##1 !wr_commit[*2]
		|-> cnt_reg[A_SEC10] == 4'h0 && $past(cnt_reg[A_SEC10], 1) == 4'h0)
		else $error("adjust left seconds");
	a_stop_freeze:  assert property (ctrl_f_reg[F_STOP] |-> !tick_sec)
		else $error("tick while stopped");
	a_irq_output:   assert property (irq_reg && ctrl_e_reg[E_ITRPT] && !ctrl_e_reg[E_MASK]
		&& $stable(ctrl_e_reg) |-> o_periodic_pulse_out_oe)
		else $error("interrupt not on pin");
	a_sec_digit:    assert property (cnt_reg[A_SEC1] <= TOP_9 || $past(wr_commit))
		else $error("seconds digit not BCD");

	c_read:   cover property (o_data_oe ##1 !o_data_oe);
	c_write:  cover property (wr_commit && wr_addr == A_CTRL_F);
	c_adjust: cover property (adj && cnt_reg[A_SEC10] >= SEC10_HALF);
	c_irq:    cover property (o_periodic_pulse_out_oe ##1 !o_periodic_pulse_out_oe);
endmodule

// >>> tb/rtc_host_model.sv
/*
 Host-side model of the clock core's microprocessor: RAM-like nibble bus with
 optional address latch. Assumes the bench calls its tasks and a shared core clock.
*/
`timescale 1ns/100ps
module rtc_host_model
	import rtc_pkg::*;
(
	// clock
	input  wire logic             i_core_clk,
	// device answer
	input  wire logic [NIB_W-1:0] i_data,
	input  wire logic             i_data_oe,
	// host pins
	output logic                  o_ale,
	output logic      [3:0]       o_addr,
	output logic                  o_sel_n,
	output logic                  o_stby,
	output logic                  o_rd_n,
	output logic                  o_wr_n,
	output logic      [NIB_W-1:0] o_data
);
	initial
	begin
		o_ale = 1'b1;
		o_addr = 4'h0;
		o_sel_n = 1'b0;
		o_stby = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_data = 4'h0;
	end

	// a host without a latch strobe keeps the latch enable high
	task automatic pins(input logic sel_n, input logic stby);
	begin
		@(negedge i_core_clk);
		o_ale = 1'b1;
		o_sel_n = sel_n;
		o_stby = stby;
	end
	endtask

	task automatic latch(input logic [3:0] a, input logic sel_n);
	begin
		@(negedge i_core_clk);
		o_addr = a;
		o_sel_n = sel_n;
		o_ale = 1'b1;
		@(negedge i_core_clk);
		o_ale = 1'b0;
		@(negedge i_core_clk);
		o_addr = ~a;
		o_sel_n = 1'b1;
	end
	endtask

	task automatic wr(input logic [3:0] a, input logic [3:0] d);
	begin
		@(negedge i_core_clk);
		o_addr = a;
		o_data = d;
		o_wr_n = 1'b0;
		repeat (3) @(negedge i_core_clk);
		o_wr_n = 1'b1;
		repeat (4) @(negedge i_core_clk);
		// released data lines do not keep the last value
		o_data = ~d;
	end
	endtask

	task automatic rd(input logic [3:0] a, output logic [3:0] d, output logic oe);
		int n;
	begin
		@(negedge i_core_clk);
		o_addr = a;
		o_rd_n = 1'b0;
		n = 0;
		while (i_data_oe !== 1'b1 && n < 6)
		begin
			@(negedge i_core_clk);
			n++;
		end
		oe = i_data_oe;
		d = i_data;
		o_rd_n = 1'b1;
		repeat (4) @(negedge i_core_clk);
	end
	endtask
endmodule

// >>> tb/tb_rtc_core.sv
/*
 Self-checking bench for the clock core: table of register accesses, then
 refusal, latch, adjust, periodic output and calendar rollover cases.
 Assumes one core clock; the crystal is toggled from the bench.
*/
`timescale 1ns/100ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %0t %s", $time, m); end end
module tb_rtc_core;
	import rtc_pkg::*;
	typedef struct packed {logic [3:0] a; logic [3:0] w; logic [3:0] e;} row_t;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic xtal = 1'b0;
	logic xtal_run = 1'b0;
	logic ale, sel_n, stby, rd_n, wr_n, oe, pulse, pulse_oe, dv, xout;
	logic [3:0] addr, wdata, rdata, d;
	int err_count = 0;
	int n_compared = 0;
	row_t rows [0:13] = '{'{4'h0, 4'h9, 4'h9}, '{4'h1, 4'hF, 4'h7}, '{4'h2, 4'h4, 4'h4},
		'{4'h3, 4'hF, 4'h7}, '{4'h4, 4'h8, 4'h8}, '{4'h5, 4'hF, 4'h7}, '{4'h7, 4'hF, 4'h3},
		'{4'h9, 4'hF, 4'h1}, '{4'hB, 4'h9, 4'h9}, '{4'hC, 4'hF, 4'h7}, '{4'hE, 4'h3, 4'h3},
		'{4'hD, 4'h1, 4'h1}, '{4'hD, 4'h0, 4'h0}, '{4'hE, 4'h0, 4'h0}};
	logic [3:0] cal [0:9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h9, 4'h2, 4'h2, 4'h0};
	// one second before midnight on the 28th of February
	logic [3:0] setv [0:9] = '{4'h9, 4'h5, 4'h9, 4'h5, 4'h3, 4'h2, 4'h8, 4'h2, 4'h2, 4'h0};

	always #5 i_core_clk = ~i_core_clk;
	// crystal at half the core rate keeps one second near 65536 cycles
	always @(negedge i_core_clk)
		if (xtal_run)
			xtal <= ~xtal;

	rtc_host_model host (.i_core_clk(i_core_clk), .i_data(rdata), .i_data_oe(oe),
		.o_ale(ale), .o_addr(addr), .o_sel_n(sel_n), .o_stby(stby), .o_rd_n(rd_n),
		.o_wr_n(wr_n), .o_data(wdata));
	rtc_core dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ale(ale), .i_addr(addr),
		.i_select_active_low(sel_n), .i_standby_select(stby), .i_rd_n(rd_n), .i_wr_n(wr_n),
		.i_data(wdata), .o_data(rdata), .o_data_oe(oe), .i_crystal_in(xtal),
		.o_crystal_out(xout), .o_periodic_pulse_out(pulse), .o_periodic_pulse_out_oe(pulse_oe));

	task automatic rchk(input logic [3:0] a, input logic [3:0] e);
	begin
		host.rd(a, d, dv);
		`CHK(dv, 1'b1, "read not driven")
		`CHK(d, e, "read value")
		`CHK(oe, 1'b0, "drive kept after read")
	end
	endtask

	task automatic give_verdict();
	begin
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask

	initial
	begin
		#800000;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		give_verdict();
	end

	initial
	begin
		repeat (20) @(negedge i_core_clk);
		i_resetn = 1'b1;
		for (int a = 0; a < 16; a++)
			rchk(4'(a), (a == 6 || a == 8) ? 4'h1 : 4'h0);
		$display("reset values done");
		foreach (rows[i])
		begin
			host.wr(rows[i].a, rows[i].w);
			rchk(rows[i].a, rows[i].e);
		end
		$display("register table done");
		host.pins(1'b1, 1'b1);
		host.wr(4'h2, 4'h9);
		host.rd(4'h2, d, dv);
		`CHK(dv, 1'b0, "drive while deselected")
		host.pins(1'b0, 1'b0);
		host.wr(4'h2, 4'h9);
		host.rd(4'h2, d, dv);
		`CHK(dv, 1'b0, "drive in standby")
		host.pins(1'b0, 1'b1);
		rchk(4'h2, 4'h4);
		$display("refusal done");
		host.latch(4'h2, 1'b0);
		host.wr(4'h5, 4'h1);
		rchk(4'h5, 4'h1);
		host.pins(1'b0, 1'b1);
		rchk(4'h2, 4'h1);
		rchk(4'h5, 4'h7);
		$display("address latch done");
		host.wr(4'h1, 4'h3);
		host.wr(4'h0, 4'h5);
		host.wr(4'h2, 4'h4);
		host.wr(4'hD, 4'h8);
		rchk(4'h0, 4'h0);
		rchk(4'h1, 4'h0);
		rchk(4'h2, 4'h5);
		host.wr(4'h1, 4'h2);
		host.wr(4'hD, 4'h8);
		rchk(4'h1, 4'h0);
		rchk(4'h2, 4'h5);
		$display("adjust done");
		host.wr(4'hE, 4'h2);
		host.pins(1'b1, 1'b1);
		xtal_run = 1'b1;
		for (int n = 0; n < 1500 && pulse_oe !== 1'b1; n++)
			@(negedge i_core_clk);
		xtal_run = 1'b0;
		`CHK(pulse_oe, 1'b1, "no periodic event while deselected")
		`CHK(pulse, 1'b0, "open drain level")
		host.pins(1'b0, 1'b1);
		rchk(4'hD, 4'h4);
		host.wr(4'hD, 4'h0);
		`CHK(pulse_oe, 1'b0, "periodic output not cleared")
		$display("periodic output done");
		host.wr(4'hF, 4'h5);
		for (int a = 0; a < 10; a++)
			host.wr(4'(a), setv[a]);
		// year 96 is a leap year, so February runs to the 29th
		host.wr(4'hA, 4'h6);
		host.wr(4'hE, 4'h0);
		host.wr(4'hF, 4'h4);
		xtal_run = 1'b1;
		repeat (65000) @(negedge i_core_clk);
		rchk(4'h0, 4'h9);
		repeat (1000) @(negedge i_core_clk);
		xtal_run = 1'b0;
		for (int a = 0; a < 10; a++)
			rchk(4'(a), cal[a]);
		`CHK(xout, ~xtal, "crystal drive")
		$display("calendar rollover done");
		host.wr(4'hF, 4'h0);
		host.wr(4'h5, 4'h5);
		host.wr(4'h4, 4'h1);
		host.wr(4'h3, 4'h5);
		host.wr(4'h2, 4'h9);
		host.wr(4'h1, 4'h3);
		host.wr(4'hD, 4'h8);
		rchk(4'h4, 4'h2);
		rchk(4'h5, 4'h1);
		rchk(4'h6, 4'h1);
		rchk(4'h8, 4'h3);
		$display("12-hour rollover done");
		give_verdict();
	end
endmodule
